// ### verilog/afe_regs.sv
/*
 * APB register slice: spare words, front-end configuration, monitor alarms,
 * check-error and revision status, plus interrupt status and mask.
 * Assumes an APB master on clk and monitor and error inputs synchronous to clk.
 */
`default_nettype none
// Functional notes
// - Switch code 000 selects external input, 101 mid-supply, reset 101.
// - Gain codes 0 to 11 map 0.125 up to 128; higher codes reserved.
// - Configuration register at 10h resets to 50h; bit 7 reserved.
// - Alarm register at 11h holds eight read-only monitor alarm bits.
// - Alarm bit reads one while active; a read clears the bits.
// - Alarm register has no defined reset value.
// - Status bit 4 sets on check error, held until written zero.
// - Status bits 3 to 0 give a revision value.
// - Spare register 0Eh reads 00h; host writes only 00h.
// - Spare register 0Fh reads 00h; host writes only 00h.
module afe_regs
    import afe_pkg::*;
#(
    parameter logic [3:0] REVISION = AFE_REVISION_DEFAULT // Arbitrary value.
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Monitor and link events.
    input  wire afe_alarm_t  alarm_in,
    input  wire logic        chk_err_second_select,
    // Front-end controls.
    output logic      [11:0] gain_onehot,
    output logic             sel_external,
    output logic             sel_midsupply,
    output afe_config_t      config_out,
    // Interrupt.
    output logic             irq
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    afe_config_t cfg_q, cfg_d;
    afe_alarm_t  alarm_q, alarm_d;
    logic        chk_q, chk_d;
    logic [1:0]  ists_q, ists_d;
    logic [1:0]  imsk_q, imsk_d;
    logic [31:0] rdata_q, rdata_d;
    logic        ready_q, ready_d;
    logic        err_q, err_d;
    logic        irq_q, irq_d;
    logic [11:0] gain_q, gain_d;
    logic        ext_q, ext_d, mid_q, mid_d;
    logic [11:0] dec_gain;
    logic        dec_ext, dec_mid, dec_rsvd;

    logic setup, acc, wr, rd, mapped, wr_lane0;
    assign setup    = psel && !penable;
    assign acc      = psel && penable && ready_q;
    assign wr       = acc && pwrite;
    assign rd       = acc && !pwrite;
    assign wr_lane0 = wr && pstrb[0];
    assign mapped   = (paddr == AFE_ADDR_SPARE_0E) || (paddr == AFE_ADDR_SPARE_0F) ||
                      (paddr == AFE_ADDR_CONFIG) || (paddr == AFE_ADDR_ALARM) ||
                      (paddr == AFE_ADDR_STATUS) || (paddr == AFE_ADDR_IRQ_STAT) ||
                      (paddr == AFE_ADDR_IRQ_MASK);

    // --------------------------------------------------------------
    // Decoder
    // --------------------------------------------------------------
    afe_gain_decode u_dec (
        .gain_code     (cfg_q.gain),
        .switch_code   (cfg_q.input_switch_select),
        .gain_onehot   (dec_gain),
        .sel_external  (dec_ext),
        .sel_midsupply (dec_mid),
        .code_reserved (dec_rsvd)
    );

    // --------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------
    // No wait state: setup arms pready, access completes the next cycle.
    // Read data is captured from the current state at setup, so a clearing
    // read returns what was held before the clear.
    always_comb begin
        cfg_d   = cfg_q;
        alarm_d = alarm_q;
        chk_d   = chk_q;
        ists_d  = ists_q;
        imsk_d  = imsk_q;
        rdata_d = rdata_q;
        err_d   = 1'b0; // Error flag stands with pready only.
        ready_d = setup;
        if (setup) begin
            err_d   = !mapped;
            rdata_d = 32'h0000_0000;
            case (paddr)
                AFE_ADDR_SPARE_0E: rdata_d[7:0] = AFE_RST_SPARE;
                AFE_ADDR_SPARE_0F: rdata_d[7:0] = AFE_RST_SPARE;
                AFE_ADDR_CONFIG:   rdata_d[7:0] = cfg_q;
                AFE_ADDR_ALARM:    rdata_d[7:0] = alarm_q;
                AFE_ADDR_STATUS:   rdata_d[7:0] = {3'h0, chk_q, REVISION};
                AFE_ADDR_IRQ_STAT: rdata_d[1:0] = ists_q;
                AFE_ADDR_IRQ_MASK: rdata_d[1:0] = imsk_q;
                default:           rdata_d = 32'h0000_0000;
            endcase
        end
        // Configuration write; reserved bit 7 is forced to zero.
        if (wr_lane0 && paddr == AFE_ADDR_CONFIG) begin
            cfg_d      = pwdata[7:0];
            cfg_d.rsvd = 1'b0;
        end
        // Check-error flag: write zero clears, a new error wins.
        if (wr_lane0 && paddr == AFE_ADDR_STATUS && !pwdata[AFE_CHK_ERR_BIT]) begin
            chk_d = 1'b0;
        end
        if (chk_err_second_select) begin
            chk_d = 1'b1;
        end
        // Alarms: read clears, then live alarms set again so none is lost.
        if (rd && paddr == AFE_ADDR_ALARM) begin
            alarm_d = 8'h00;
        end
        alarm_d = alarm_d | alarm_in;
        if (wr_lane0 && paddr == AFE_ADDR_IRQ_MASK) begin
            imsk_d = pwdata[1:0];
        end
        if (wr_lane0 && paddr == AFE_ADDR_IRQ_STAT) begin
            ists_d = ists_q & ~pwdata[1:0];
        end
        if (|alarm_in) begin
            ists_d[AFE_IRQ_ALARM] = 1'b1;
        end
        if (chk_err_second_select) begin
            ists_d[AFE_IRQ_CHK_ERR] = 1'b1;
        end
    end

    // Outputs registered so that all leave a flop: irq from the next values, gain and switch lines decoded from the current configuration.
    always_comb begin
        irq_d  = |(ists_d & imsk_d);
        gain_d = dec_gain;
        ext_d  = dec_ext;
        mid_d  = dec_mid;
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    // Alarm bits take zero at reset only because a flop needs a constant;
    // software must treat them as undefined until a monitor update.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q   <= AFE_RST_CONFIG;
            alarm_q <= 8'h00;
            chk_q   <= 1'b0;
            ists_q  <= AFE_RST_IRQ;
            imsk_q  <= AFE_RST_IRQ;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
            irq_q   <= 1'b0;
            gain_q  <= 12'h001;
            ext_q   <= 1'b0;
            mid_q   <= 1'b1;
        end else begin
            cfg_q   <= cfg_d;
            alarm_q <= alarm_d;
            chk_q   <= chk_d;
            ists_q  <= ists_d;
            imsk_q  <= imsk_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q   <= err_d;
            irq_q   <= irq_d;
            gain_q  <= gain_d;
            ext_q   <= ext_d;
            mid_q   <= mid_d;
        end
    end

    assign prdata        = rdata_q;
    assign pready        = ready_q;
    assign pslverr       = err_q;
    assign irq           = irq_q;
    assign gain_onehot   = gain_q;
    assign sel_external  = ext_q;
    assign sel_midsupply = mid_q;
    assign config_out    = cfg_q;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    property p_cfg_rsvd;
        @(posedge clk) disable iff (rst) cfg_q.rsvd == 1'b0;
    endproperty
    a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config bit 7 set");

    property p_alarm_clear;
        @(posedge clk) disable iff (rst)
            (rd && paddr == AFE_ADDR_ALARM) |=> (alarm_q == $past(alarm_in));
    endproperty
    a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared");

    property p_alarm_hold;
        @(posedge clk) disable iff (rst)
            !(rd && paddr == AFE_ADDR_ALARM) |=> ((alarm_q & $past(alarm_q)) == $past(alarm_q));
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm lost");

    property p_chk_set;
        @(posedge clk) disable iff (rst) chk_err_second_select |=> chk_q;
    endproperty
    a_chk_set: assert property (p_chk_set) else $error("check error missed");

    property p_chk_hold;
        @(posedge clk) disable iff (rst)
            (chk_q && !(wr && paddr == AFE_ADDR_STATUS)) |=> chk_q;
    endproperty
    a_chk_hold: assert property (p_chk_hold) else $error("check error dropped");

    property p_spare_read;
        @(posedge clk) disable iff (rst)
            (setup && (paddr == AFE_ADDR_SPARE_0E || paddr == AFE_ADDR_SPARE_0F))
            |=> (prdata == 32'h0000_0000) && pready;
    endproperty
    a_spare_read: assert property (p_spare_read) else $error("spare not zero");

    property p_status_read;
        @(posedge clk) disable iff (rst)
            (setup && paddr == AFE_ADDR_STATUS)
            |=> (prdata[7:5] == 3'h0) && (prdata[3:0] == REVISION);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_switch;
        @(posedge clk) disable iff (rst)
            ##1 (sel_midsupply == ($past(cfg_q.input_switch_select) == AFE_SW_MIDSUPPLY));
    endproperty
    a_switch: assert property (p_switch) else $error("switch decode wrong");

    property p_gain;
        @(posedge clk) disable iff (rst)
            ##1 ($past(cfg_q.gain) > AFE_GAIN_MAX) == (gain_onehot == 12'h000);
    endproperty
    a_gain: assert property (p_gain) else $error("gain decode wrong");

    property p_switch_ext;
        @(posedge clk) disable iff (rst)
            ##1 (sel_external == ($past(cfg_q.input_switch_select) == AFE_SW_EXTERNAL));
    endproperty
    a_switch_ext: assert property (p_switch_ext) else $error("external select wrong");

    // One gain line per legal code, and the line of that very code.
    property p_gain_onehot;
        @(posedge clk) disable iff (rst)
            ##1 ($past(cfg_q.gain) <= AFE_GAIN_MAX)
            |-> (gain_onehot == (12'h001 << $past(cfg_q.gain)));
    endproperty
    a_gain_onehot: assert property (p_gain_onehot) else $error("gain line wrong");

    property p_code_reserved;
        @(posedge clk) disable iff (rst)
            (cfg_q.gain > AFE_GAIN_MAX) |-> (dec_rsvd && (dec_gain == 12'h000));
    endproperty
    a_code_reserved: assert property (p_code_reserved) else $error("reserved gain used");

    property p_switch_reserved;
        @(posedge clk) disable iff (rst)
            (cfg_q.input_switch_select != AFE_SW_EXTERNAL &&
             cfg_q.input_switch_select != AFE_SW_MIDSUPPLY)
            |-> (dec_rsvd && !dec_ext && !dec_mid);
    endproperty
    a_switch_reserved: assert property (p_switch_reserved) else $error("reserved switch used");

    property p_cfg_write;
        @(posedge clk) disable iff (rst)
            (wr_lane0 && paddr == AFE_ADDR_CONFIG) |=> (cfg_q == {1'b0, $past(pwdata[6:0])});
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    // Nothing but a configuration write may move the configuration word.
    property p_cfg_hold;
        @(posedge clk) disable iff (rst)
            !(wr_lane0 && paddr == AFE_ADDR_CONFIG) |=> $stable(cfg_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed unasked");

    property p_alarm_read;
        @(posedge clk) disable iff (rst)
            (setup && paddr == AFE_ADDR_ALARM) |=> (prdata[7:0] == $past(alarm_q));
    endproperty
    a_alarm_read: assert property (p_alarm_read) else $error("alarm read not pre-clear");

    // A clearing write with no new error in that cycle must drop the flag.
    property p_chk_clear;
        @(posedge clk) disable iff (rst)
            (wr_lane0 && paddr == AFE_ADDR_STATUS && !pwdata[AFE_CHK_ERR_BIT] &&
             !chk_err_second_select) |=> !chk_q;
    endproperty
    a_chk_clear: assert property (p_chk_clear) else $error("check error not cleared");

    property p_unmapped;
        @(posedge clk) disable iff (rst)
            (setup && !mapped) |=> (pslverr && pready && (prdata == 32'h0000_0000));
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule : afe_regs
`default_nettype wire

// ### inc/afe_pkg.sv
/*
 * Package for the front-end configuration and status register slice.
 * Assumes a 32-bit APB slave, one aligned word per register, 8-bit data in the low bits.
 */
`default_nettype none
package afe_pkg;
    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0]  AFE_IDX_SPARE_0E = 8'h0E;
    localparam logic [7:0]  AFE_IDX_SPARE_0F = 8'h0F;
    localparam logic [7:0]  AFE_IDX_CONFIG   = 8'h10;
    localparam logic [7:0]  AFE_IDX_ALARM    = 8'h11;
    localparam logic [7:0]  AFE_IDX_STATUS   = 8'h12;
    localparam logic [7:0]  AFE_IDX_IRQ_STAT = 8'h20;
    localparam logic [7:0]  AFE_IDX_IRQ_MASK = 8'h21;
    localparam logic [11:0] AFE_ADDR_SPARE_0E = {2'h0, AFE_IDX_SPARE_0E, 2'h0};
    localparam logic [11:0] AFE_ADDR_SPARE_0F = {2'h0, AFE_IDX_SPARE_0F, 2'h0};
    localparam logic [11:0] AFE_ADDR_CONFIG   = {2'h0, AFE_IDX_CONFIG, 2'h0};
    localparam logic [11:0] AFE_ADDR_ALARM    = {2'h0, AFE_IDX_ALARM, 2'h0};
    localparam logic [11:0] AFE_ADDR_STATUS   = {2'h0, AFE_IDX_STATUS, 2'h0};
    localparam logic [11:0] AFE_ADDR_IRQ_STAT = {2'h0, AFE_IDX_IRQ_STAT, 2'h0};
    localparam logic [11:0] AFE_ADDR_IRQ_MASK = {2'h0, AFE_IDX_IRQ_MASK, 2'h0};

    // ------------------------------------------------------------------
    // Reset values and field codes
    // ------------------------------------------------------------------
    localparam logic [7:0] AFE_RST_SPARE   = 8'h00;
    localparam logic [7:0] AFE_RST_CONFIG  = 8'h50;
    localparam logic [2:0] AFE_SW_EXTERNAL = 3'h0;
    localparam logic [2:0] AFE_SW_MIDSUPPLY = 3'h5;
    localparam logic [3:0] AFE_GAIN_MAX    = 4'hB;
    localparam int         AFE_CHK_ERR_BIT = 4;
    localparam logic [3:0] AFE_REVISION_DEFAULT = 4'h1; // Arbitrary value.
    localparam logic [1:0] AFE_RST_IRQ     = 2'h0;

    // Interrupt status bit positions.
    localparam int AFE_IRQ_ALARM   = 0;
    localparam int AFE_IRQ_CHK_ERR = 1;

    // Front-end configuration fields.
    typedef struct packed {
        logic       rsvd;
        logic [2:0] input_switch_select;
        logic [3:0] gain;
    } afe_config_t;

    // Eight monitor alarm bits, bit 7 first.
    typedef struct packed {
        logic out_neg_low_alarm;
        logic out_neg_high_alarm;
        logic out_pos_low_alarm;
        logic out_pos_high_alarm;
        logic in_neg_low_alarm;
        logic in_neg_high_alarm;
        logic in_pos_low_alarm;
        logic in_pos_high_alarm;
    } afe_alarm_t;
endpackage : afe_pkg
`default_nettype wire

// ### verilog/afe_gain_decode.sv
/*
 * Decodes the gain and input switch codes into one-hot controls for the analog path.
 * Assumes the codes come straight from the configuration register.
 */
`default_nettype none
module afe_gain_decode
    import afe_pkg::*;
(
    // Codes in.
    input  wire logic [3:0]  gain_code,
    input  wire logic [2:0]  switch_code,
    // Decoded controls.
    output logic      [11:0] gain_onehot,
    output logic             sel_external,
    output logic             sel_midsupply,
    output logic             code_reserved
);
    // --------------------------------------------------------------
    // Decode
    // --------------------------------------------------------------
    // Reserved gain codes give no gain line at all, so the path stays idle.
    always_comb begin
        gain_onehot   = 12'h000;
        if (gain_code <= AFE_GAIN_MAX) begin
            gain_onehot[gain_code] = 1'b1;
        end
        sel_external  = (switch_code == AFE_SW_EXTERNAL);
        sel_midsupply = (switch_code == AFE_SW_MIDSUPPLY);
        code_reserved = (gain_code > AFE_GAIN_MAX) || !(sel_external || sel_midsupply);
    end
endmodule : afe_gain_decode
`default_nettype wire

// ### testbench/afe_host_model.sv
/*
 * Host side model: an APB master that drives the register slice.
 * Assumes one clock and a slave that answers with pready.
 */
`default_nettype none
module afe_host_model (
    // Clock.
    input  wire logic        clk,
    // APB request.
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    // APB answer.
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Bus idle at time zero
    // ----------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
    end

    // One transfer; caller writes zero to reserved bits and spares.
    task xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
              output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        // Released lines show the inverse so a stale value never passes.
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~{24'h000000, d};
        @(posedge clk);
    endtask : xfer
endmodule : afe_host_model
`default_nettype wire

// ### testbench/tb_afe_regs.sv
/*
 * Self-checking bench for the register slice, driven through the host model.
 * Assumes the designer's zero-wait-state APB timing.
 */
`default_nettype none
module tb_afe_regs
    import afe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] REV = 4'h6; // Arbitrary value.
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, chk_err, sx, sm, irq;
    logic [11:0] paddr, gh;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb, gv;
    logic [2:0]  sv;
    logic        e;
    afe_alarm_t  alarm_in;
    afe_config_t cfg;
    int          miscompares, n_tests, cyc;

    afe_regs #(.REVISION(REV)) u_afe_regs (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .alarm_in(alarm_in), .chk_err_second_select(chk_err), .gain_onehot(gh),
        .sel_external(sx), .sel_midsupply(sm), .config_out(cfg), .irq(irq));
    afe_host_model u_afe_host_model (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task rd(input logic [11:0] a, input logic [31:0] x);
        u_afe_host_model.xfer(1'b0, a, 8'h00, r, e);
        chk(r, x);
    endtask : rd
    task wr(input logic [11:0] a, input logic [7:0] d);
        u_afe_host_model.xfer(1'b1, a, d, r, e);
    endtask : wr
    task close_out;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    // Free-running clock at 8 ns.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // A hang counts as a mismatch; the tests need well under this.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            close_out();
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        chk_err = 1'b0;
        alarm_in = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(AFE_ADDR_SPARE_0E, 32'h00000000);
        rd(AFE_ADDR_SPARE_0F, 32'h00000000);
        rd(AFE_ADDR_CONFIG, 32'h00000050);
        chk({7'h00, gh, 3'h0, sx, sm, cfg}, {7'h00, 12'h001, 5'h01, 8'h50});
        rd(AFE_ADDR_STATUS, {28'h0000000, REV});
        rd(AFE_ADDR_IRQ_MASK, 32'h00000000);
        u_afe_host_model.xfer(1'b0, 12'h0FC, 8'h00, r, e);
        chk({e, r[30:0]}, 32'h80000000);
        $display("test reset_and_map done");
        for (int s = 0; s < 3; s++) begin
            sv = (s == 0) ? AFE_SW_EXTERNAL : (s == 1) ? AFE_SW_MIDSUPPLY : 3'h3;
            for (int g = 0; g < 16; g++) begin
                gv = g[3:0];
                wr(AFE_ADDR_CONFIG, {1'b0, sv, gv});
                rd(AFE_ADDR_CONFIG, {24'h000000, 1'b0, sv, gv});
                chk({20'h00000, gh}, (g < 12) ? (32'h00000001 << g) : 32'h00000000);
                chk({30'h00000000, sx, sm}, {30'h00000000, sv == 3'h0, sv == 3'h5});
                chk({24'h000000, cfg}, {24'h000000, 1'b0, sv, gv});
            end
        end
        $display("test config_codes done");
        u_afe_host_model.xfer(1'b0, AFE_ADDR_ALARM, 8'h00, r, e);
        wr(AFE_ADDR_IRQ_STAT, 8'h03);
        wr(AFE_ADDR_IRQ_MASK, 8'h01);
        for (int i = 0; i < 8; i++) begin
            alarm_in <= afe_alarm_t'(8'h01 << i);
            @(posedge clk);
            alarm_in <= '0;
            wr(AFE_ADDR_ALARM, 8'h00);
            chk({31'h00000000, irq}, 32'h00000001);
            rd(AFE_ADDR_ALARM, 32'h00000001 << i);
            rd(AFE_ADDR_ALARM, 32'h00000000);
            wr(AFE_ADDR_IRQ_STAT, 8'h01);
            repeat (2) @(posedge clk);
            chk({31'h00000000, irq}, 32'h00000000);
        end
        // An alarm still active during the clearing read survives it.
        alarm_in <= afe_alarm_t'(8'h80);
        @(posedge clk);
        rd(AFE_ADDR_ALARM, 32'h00000080);
        alarm_in <= '0;
        rd(AFE_ADDR_ALARM, 32'h00000080);
        rd(AFE_ADDR_ALARM, 32'h00000000);
        wr(AFE_ADDR_IRQ_STAT, 8'h01);
        $display("test alarm_flags done");
        chk_err <= 1'b1;
        @(posedge clk);
        chk_err <= 1'b0;
        wr(AFE_ADDR_STATUS, 8'h10);
        rd(AFE_ADDR_STATUS, {27'h0000000, 1'b1, REV});
        rd(AFE_ADDR_IRQ_STAT, 32'h00000002);
        chk({31'h00000000, irq}, 32'h00000000);
        wr(AFE_ADDR_IRQ_MASK, 8'h02);
        repeat (2) @(posedge clk);
        chk({31'h00000000, irq}, 32'h00000001);
        wr(AFE_ADDR_STATUS, 8'h00);
        rd(AFE_ADDR_STATUS, {28'h0000000, REV});
        wr(AFE_ADDR_IRQ_STAT, 8'h02);
        repeat (2) @(posedge clk);
        rd(AFE_ADDR_IRQ_STAT, 32'h00000000);
        chk({31'h00000000, irq}, 32'h00000000);
        // An error in the same cycle as the clearing write keeps the flag set.
        chk_err <= 1'b1;
        wr(AFE_ADDR_STATUS, 8'h00);
        chk_err <= 1'b0;
        rd(AFE_ADDR_STATUS, {27'h0000000, 1'b1, REV});
        wr(AFE_ADDR_STATUS, 8'h00);
        rd(AFE_ADDR_STATUS, {28'h0000000, REV});
        $display("test check_error done");
        close_out();
    end
endmodule : tb_afe_regs
`default_nettype wire
